// File: shared/bst_pkg.sv
// Purpose: Shared constants and types for the boundary-scan test access port
// Assumes: Test clock is sampled by the 200 MHz system clock
// Notes: Instruction codes are four bits wide, shifted least significant bit first
package bst_pkg;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam int unsigned BST_IR_W = 4;
  localparam logic [3:0] BST_INS_EXTEST = 4'h0;
  localparam logic [3:0] BST_INS_SAMPLE = 4'h1;
  localparam logic [3:0] BST_INS_INTEST = 4'h4;
  localparam logic [3:0] BST_INS_CLAMP = 4'h5;
  localparam logic [3:0] BST_INS_BYPASS = 4'hF;
  localparam logic [3:0] BST_IR_RESET = 4'hF;

  // ----------------------------------------------------------------
  // Captured instruction pattern bit positions (p00s / p001)
  // ----------------------------------------------------------------
  localparam int unsigned BST_CAP_LSB_POS = 0;
  localparam int unsigned BST_CAP_PROT_POS = 3;

  // ----------------------------------------------------------------
  // Chain size
  // ----------------------------------------------------------------
  localparam int unsigned BST_PIN_N = 8;
  localparam int unsigned BST_CORE_N = 8;
  localparam int unsigned BST_CHAIN_N = BST_PIN_N + BST_CORE_N;

  // ----------------------------------------------------------------
  // Controller states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    BST_ST_RESET = 16'h0001,
    BST_ST_IDLE = 16'h0002,
    BST_ST_SEL_DR = 16'h0004,
    BST_ST_CAP_DR = 16'h0008,
    BST_ST_SH_DR = 16'h0010,
    BST_ST_EX1_DR = 16'h0020,
    BST_ST_PAU_DR = 16'h0040,
    BST_ST_EX2_DR = 16'h0080,
    BST_ST_UPD_DR = 16'h0100,
    BST_ST_SEL_IR = 16'h0200,
    BST_ST_CAP_IR = 16'h0400,
    BST_ST_SH_IR = 16'h0800,
    BST_ST_EX1_IR = 16'h1000,
    BST_ST_PAU_IR = 16'h2000,
    BST_ST_EX2_IR = 16'h4000,
    BST_ST_UPD_IR = 16'h8000
  } bst_state_t;

  // Pin group carried as one struct
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bst_link_t;

  // Synchroniser stages for the three link pins
  typedef struct packed {
    bst_link_t s1;
    bst_link_t s2;
    bst_link_t s3;
  } bst_sync_t;

  // Whole module state
  typedef struct packed {
    bst_sync_t sync;
    logic tck_q;
    bst_state_t st;
    logic [BST_IR_W-1:0] ir_sh;
    logic [BST_IR_W-1:0] ir;
    logic [BST_CHAIN_N-1:0] chain;
    logic [BST_CHAIN_N-1:0] upd;
    logic byp;
    logic tdo;
    logic tdo_sel;
    logic [BST_PIN_N-1:0] pin_out;
    logic pin_test;
    logic [BST_CORE_N-1:0] core_in;
    logic core_test;
  } bst_regs_t;

endpackage

// File: design/bst_tap.sv
// Purpose: Boundary-scan test access port with four instructions, three of them chain instructions
// Assumes: Test clock, mode and data pins come from an external tester, asynchronous to clk
// Notes: The test clock is oversampled; edges act one cycle after the second and third stages agree
//
// Overview of operation
// - Code 0000 picks the boundary-scan chain as data register for external testing.
// - External test drives held chain outputs onto pins as soon as it is loaded.
// - Capture-IR loads p00s, or p001 under internal test, into the instruction shifter.
// - Shift-IR moves the instruction shifter one bit each test clock.
// - External test capture-DR samples the pin values into the chain.
// - Shift-DR moves the chain one position per test clock under chain instructions.
// - External test and clamp apply held chain data to output pins at update-IR.
// - External test update-DR transfers shifted chain contents to the output pins.
// - Code 0001 selects the chain; snapshots and preloads without touching outputs.
// - Sample/preload capture-DR samples pins into the chain; it has no update step.
// - Code 0100 tests internal logic: chain feeds inputs, captures outputs, drives pins.
// - Internal test update-IR and update-DR apply chain data to internal logic inputs.
// - Internal test capture-DR samples internal logic outputs into the chain.
// - Code 0101 selects one-bit bypass while output pins stay driven from chain.
// - Clamp capture-DR loads zero into the bypass register.
// - Clamp shift-DR passes test data in through one bypass stage to test data out.
// - Captured p bit shows protection; s bit reads one after good start-up.
// - All patterns shift least significant bit first.
// - Instructions are seen in parallel; output selected only for recognised instructions.
`timescale 1ns/10ps

module bst_tap
  import bst_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Test link pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_sel,
  // Chip status
  input wire logic chip_protected,
  input wire logic startup_done,
  // Pad side: cell i of the chain is pin i
  input wire logic [BST_PIN_N-1:0] pin_in,
  output logic [BST_PIN_N-1:0] pin_out,
  output logic pin_test,
  // Core side: cells above the pins face the internal logic
  input wire logic [BST_CORE_N-1:0] core_out,
  output logic [BST_CORE_N-1:0] core_in,
  output logic core_test
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Instructions owned by this port; anything else belongs to the debug port
  function automatic logic ins_known(input logic [BST_IR_W-1:0] c);
    ins_known = (c == BST_INS_EXTEST) || (c == BST_INS_SAMPLE) ||
                (c == BST_INS_INTEST) || (c == BST_INS_CLAMP);
  endfunction

  // Instructions whose data register is the chain
  function automatic logic ins_chain(input logic [BST_IR_W-1:0] c);
    ins_chain = (c == BST_INS_EXTEST) || (c == BST_INS_SAMPLE) || (c == BST_INS_INTEST);
  endfunction

  // Instructions that drive the pins from the held update stage
  function automatic logic ins_drives(input logic [BST_IR_W-1:0] c);
    ins_drives = (c == BST_INS_EXTEST) || (c == BST_INS_INTEST) || (c == BST_INS_CLAMP);
  endfunction

  bst_regs_t r_reg;
  bst_regs_t r_next;
  bst_link_t pins;
  logic rise;
  logic fall;

  assign pins = '{tck: tck, tms: tms, tdi: tdi};
  // Edges counted only once stages two and three agree, filtering glitches
  assign rise = (r_reg.sync.s2.tck == r_reg.sync.s3.tck) && r_reg.sync.s3.tck && !r_reg.tck_q;
  assign fall = (r_reg.sync.s2.tck == r_reg.sync.s3.tck) && !r_reg.sync.s3.tck && r_reg.tck_q;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    r_next = r_reg;
    r_next.sync.s1 = pins;
    r_next.sync.s2 = r_reg.sync.s1;
    r_next.sync.s3 = r_reg.sync.s2;
    if (r_reg.sync.s2.tck == r_reg.sync.s3.tck)
    begin
      r_next.tck_q = r_reg.sync.s3.tck;
    end
    // Rising test clock: controller move, capture and shift
    if (rise)
    begin
      case (r_reg.st)
        BST_ST_CAP_IR:
        begin
          // p in the top bit, 01 at the bottom for internal test, else 0 then startup_done
          r_next.ir_sh[BST_CAP_PROT_POS] = chip_protected;
          r_next.ir_sh[2:1] = 2'h0;
          r_next.ir_sh[BST_CAP_LSB_POS] = (r_reg.ir == BST_INS_INTEST) ? 1'b1 : startup_done;
        end
        BST_ST_SH_IR:
        begin
          r_next.ir_sh = {r_reg.sync.s3.tdi, r_reg.ir_sh[BST_IR_W-1:1]};
        end
        BST_ST_CAP_DR:
        begin
          if (r_reg.ir == BST_INS_INTEST)
          begin
            r_next.chain[BST_CHAIN_N-1:BST_PIN_N] = core_out;
            r_next.chain[BST_PIN_N-1:0] = pin_in;
          end
          else if (ins_chain(r_reg.ir))
          begin
            r_next.chain[BST_PIN_N-1:0] = pin_in;
            r_next.chain[BST_CHAIN_N-1:BST_PIN_N] = core_out;
          end
          else
          begin
            r_next.byp = 1'b0;
          end
        end
        BST_ST_SH_DR:
        begin
          if (ins_chain(r_reg.ir))
          begin
            r_next.chain = {r_reg.sync.s3.tdi, r_reg.chain[BST_CHAIN_N-1:1]};
          end
          else
          begin
            r_next.byp = r_reg.sync.s3.tdi;
          end
        end
        default:
        begin
        end
      endcase
      // Controller, driven by the tester's mode pin
      case (r_reg.st)
        BST_ST_RESET: r_next.st = r_reg.sync.s3.tms ? BST_ST_RESET : BST_ST_IDLE;
        BST_ST_IDLE: r_next.st = r_reg.sync.s3.tms ? BST_ST_SEL_DR : BST_ST_IDLE;
        BST_ST_SEL_DR: r_next.st = r_reg.sync.s3.tms ? BST_ST_SEL_IR : BST_ST_CAP_DR;
        BST_ST_CAP_DR: r_next.st = r_reg.sync.s3.tms ? BST_ST_EX1_DR : BST_ST_SH_DR;
        BST_ST_SH_DR: r_next.st = r_reg.sync.s3.tms ? BST_ST_EX1_DR : BST_ST_SH_DR;
        BST_ST_EX1_DR: r_next.st = r_reg.sync.s3.tms ? BST_ST_UPD_DR : BST_ST_PAU_DR;
        BST_ST_PAU_DR: r_next.st = r_reg.sync.s3.tms ? BST_ST_EX2_DR : BST_ST_PAU_DR;
        BST_ST_EX2_DR: r_next.st = r_reg.sync.s3.tms ? BST_ST_UPD_DR : BST_ST_SH_DR;
        BST_ST_UPD_DR: r_next.st = r_reg.sync.s3.tms ? BST_ST_SEL_DR : BST_ST_IDLE;
        BST_ST_SEL_IR: r_next.st = r_reg.sync.s3.tms ? BST_ST_RESET : BST_ST_CAP_IR;
        BST_ST_CAP_IR: r_next.st = r_reg.sync.s3.tms ? BST_ST_EX1_IR : BST_ST_SH_IR;
        BST_ST_SH_IR: r_next.st = r_reg.sync.s3.tms ? BST_ST_EX1_IR : BST_ST_SH_IR;
        BST_ST_EX1_IR: r_next.st = r_reg.sync.s3.tms ? BST_ST_UPD_IR : BST_ST_PAU_IR;
        BST_ST_PAU_IR: r_next.st = r_reg.sync.s3.tms ? BST_ST_EX2_IR : BST_ST_PAU_IR;
        BST_ST_EX2_IR: r_next.st = r_reg.sync.s3.tms ? BST_ST_UPD_IR : BST_ST_SH_IR;
        BST_ST_UPD_IR: r_next.st = r_reg.sync.s3.tms ? BST_ST_SEL_DR : BST_ST_IDLE;
        default: r_next.st = BST_ST_RESET;
      endcase
    end
    // Falling test clock: output data, updates
    if (fall)
    begin
      case (r_reg.st)
        BST_ST_SH_IR:
        begin
          r_next.tdo = r_reg.ir_sh[0];
        end
        BST_ST_SH_DR:
        begin
          r_next.tdo = ins_chain(r_reg.ir) ? r_reg.chain[0] : r_reg.byp;
        end
        BST_ST_UPD_IR:
        begin
          // Whole shifted code is seen by both ports at once
          r_next.ir = r_reg.ir_sh;
        end
        BST_ST_UPD_DR:
        begin
          // Sample/preload leaves the held outputs alone
          if ((r_reg.ir == BST_INS_EXTEST) || (r_reg.ir == BST_INS_INTEST))
          begin
            r_next.upd = r_reg.chain;
          end
        end
        BST_ST_RESET:
        begin
          r_next.ir = BST_IR_RESET;
        end
        default:
        begin
        end
      endcase
    end
    // Test modes follow the held instruction at once, so update-IR applies the held data
    r_next.tdo_sel = ins_known(r_next.ir);
    r_next.pin_test = ins_drives(r_next.ir);
    r_next.core_test = (r_next.ir == BST_INS_INTEST);
    r_next.pin_out = r_next.upd[BST_PIN_N-1:0];
    r_next.core_in = r_next.upd[BST_CHAIN_N-1:BST_PIN_N];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      r_reg <= '{st: BST_ST_RESET, ir: BST_IR_RESET, default: '0};
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from flip-flops
  assign tdo = r_reg.tdo;
  assign tdo_sel = r_reg.tdo_sel;
  assign pin_out = r_reg.pin_out;
  assign pin_test = r_reg.pin_test;
  assign core_in = r_reg.core_in;
  assign core_test = r_reg.core_test;

endmodule

// File: sim/bst_tap_assertions.sv
// Purpose: Port-level checks for the boundary-scan port
// Assumes: Test clock phases last well over ten system clocks
// Notes: Sees the top ports only
`timescale 1ns/10ps
module bst_tap_assertions
  import bst_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Test link
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_sel,
  // Status, pads and core
  input wire logic chip_protected,
  input wire logic startup_done,
  input wire logic [BST_PIN_N-1:0] pin_in,
  input wire logic [BST_PIN_N-1:0] pin_out,
  input wire logic pin_test,
  input wire logic [BST_CORE_N-1:0] core_out,
  input wire logic [BST_CORE_N-1:0] core_in,
  input wire logic core_test
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Test clock fell a short while ago and is still low
  sequence s_after_fall;
    !tck && $past(tck, 10);
  endsequence
  // Test clock high long enough for any rise to be acted on
  sequence s_high_run;
    tck [*8];
  endsequence
  property p_intest_pins; core_test |-> pin_test; endproperty
  property p_core_owns; core_test |-> tdo_sel; endproperty
  property p_pin_owns; pin_test |-> tdo_sel; endproperty
  // Reset clears outputs off any test clock edge, so the edge just after release is exempt
  property p_tdo_on_fall; !$past(sys_rst) && $changed(tdo) |-> s_after_fall; endproperty
  property p_pin_upd; !$past(sys_rst) && $changed(pin_out) |-> pin_test and s_after_fall; endproperty
  property p_core_upd; !$past(sys_rst) && $changed(core_in) |-> pin_test and s_after_fall; endproperty
  property p_sel_on_fall; !$past(sys_rst) && $changed(tdo_sel) |-> s_after_fall; endproperty
  // Outputs move only after falls; a rise steps the controller, captures and shifts
  property p_quiet_high;
    s_high_run |-> $stable(pin_out) && $stable(core_in) && $stable(tdo) && $stable(tdo_sel);
  endproperty
  a_intest_pins: assert property (p_intest_pins) else $error("internal test without pad drive");
  a_core_owns: assert property (p_core_owns) else $error("core drive without own instruction");
  a_pin_owns: assert property (p_pin_owns) else $error("pad drive without own instruction");
  a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo moved off a falling edge");
  a_pin_upd: assert property (p_pin_upd) else $error("pads updated outside an update");
  a_core_upd: assert property (p_core_upd) else $error("core inputs updated outside an update");
  a_sel_on_fall: assert property (p_sel_on_fall) else $error("tdo ownership moved off a fall");
  a_quiet_high: assert property (p_quiet_high) else $error("output moved while test clock high");
endmodule

bind bst_tap bst_tap_assertions bst_tap_assertions_i (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
  .tdi(tdi), .tdo(tdo), .tdo_sel(tdo_sel), .chip_protected(chip_protected), .startup_done(startup_done),
  .pin_in(pin_in), .pin_out(pin_out), .pin_test(pin_test), .core_out(core_out), .core_in(core_in),
  .core_test(core_test));

// File: sim/bst_tester.sv
// Purpose: Tester model driving the test link
// Assumes: 125 ns test clock, held low between frames
// Notes: The bench calls the tasks; tdi shows the inverse of its last bit when idle
`timescale 1ns/10ps
module bst_tester
(
  // Link outputs
  output logic tck,
  output logic tms,
  output logic tdi,
  // Link input
  input wire logic tdo
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One test clock; tdo taken just before the rise
  task automatic tick(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #62.5;
    q = tdo;
    tck = 1'b1;
    #62.5;
    tck = 1'b0;
  endtask
  // Idle to one scan path and back to idle
  task automatic scan(input logic is_ir, input int n, input logic [15:0] din, output logic [15:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, 1'b0, q);
    if (is_ir)
      tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tdi = ~din[n-1];
  endtask
endmodule

// File: sim/bst_tap_tb.sv
// Purpose: Self-checking bench for the boundary-scan port
// Assumes: Tester model drives the link at 125 ns
// Notes: Pad and core values stay fixed; scans use the table below, except the final status scan
`timescale 1ns/10ps
module bst_tap_tb
  import bst_pkg::*;
;
  // Row: code, length, data in, data out, capture, pads, core, pad mode, core mode
  typedef struct packed {
    logic [3:0] code;
    int n;
    logic [15:0] din;
    logic [15:0] dout;
    logic [3:0] cap;
    logic [7:0] pins;
    logic [7:0] core;
    logic pt;
    logic ct;
  } bst_row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic tck, tms, tdi, tdo, tdo_sel, pin_test, core_test, b;
  logic chip_protected = 1'b1;
  logic startup_done = 1'b0;
  logic [7:0] pin_in = 8'hC3;
  logic [7:0] core_out = 8'h6E;
  logic [7:0] pin_out, core_in, prev;
  logic [15:0] got;
  int failures = 0;
  int checks_done = 0;
  bst_row_t rows [4] = '{
    '{BST_INS_EXTEST, 16, 16'hA55A, 16'h6EC3, 4'h8, 8'h5A, 8'hA5, 1'b1, 1'b0},
    '{BST_INS_SAMPLE, 16, 16'h3C3C, 16'h6EC3, 4'h8, 8'h5A, 8'hA5, 1'b0, 1'b0},
    '{BST_INS_INTEST, 16, 16'h1234, 16'h6EC3, 4'h8, 8'h34, 8'h12, 1'b1, 1'b1},
    '{BST_INS_CLAMP, 2, 16'h0003, 16'h0002, 4'h9, 8'h34, 8'h12, 1'b1, 1'b0}};

  bst_tap bst_tap_i (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_sel(tdo_sel), .chip_protected(chip_protected), .startup_done(startup_done), .pin_in(pin_in),
    .pin_out(pin_out), .pin_test(pin_test), .core_out(core_out), .core_in(core_in), .core_test(core_test));
  bst_tester bst_tester_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  // Compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // System clock
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  // Watchdog so a hang still reaches the verdict
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    prev = 8'h00;
    repeat (10) @(posedge clk);
    #1 sys_rst = 1'b0;
    @(posedge clk);
    #1 bst_tester_i.tick(1'b0, 1'b0, b);
    foreach (rows[k])
    begin
      bst_tester_i.scan(1'b1, 4, {12'h000, rows[k].code}, got);
      check("capture", got, {12'h000, rows[k].cap});
      check("held pads", pin_out, prev);
      check("tdo owner", tdo_sel, 1'b1);
      check("pad mode", pin_test, rows[k].pt);
      check("core mode", core_test, rows[k].ct);
      bst_tester_i.scan(1'b0, rows[k].n, rows[k].din, got);
      check("scan out", got, rows[k].dout);
      check("pads", pin_out, rows[k].pins);
      check("core", core_in, rows[k].core);
      prev = rows[k].pins;
      $display("test %0d done", k);
    end
    // Status bits, then a code this port does not own
    @(posedge clk);
    #1 chip_protected = 1'b0;
    startup_done = 1'b1;
    bst_tester_i.scan(1'b1, 4, 16'h000E, got);
    check("status capture", got, 16'h0001);
    check("foreign code", tdo_sel, 1'b0);
    // Reset in mid-run clears every drive
    @(posedge clk);
    #1 sys_rst = 1'b1;
    @(posedge clk);
    #1 sys_rst = 1'b0;
    @(posedge clk);
    #1 check("reset data", {pin_out, core_in}, 16'h0000);
    check("reset modes", {tdo_sel, pin_test, core_test}, 3'b000);
    $display("test reset done");
    report_and_stop();
  end
endmodule
